/* design/scd_stage_decoder.sv */
// scd_stage_decoder: one stage command decoder behind a parallel command bus
// assumes the adapter holds register bits steady per pass, synchronous to clk
// assumes the reset bit wins when reset and execute stand together
// assumes select and address stay put for the whole code pass
// limitation: codes from 112 up pick no line but still run a pulse
// limitation: a new code pass is ignored until the decoder is idle again
// hazard: feedback reads zero while idle, as it does for an all-ones code
//
// Summary of operation
// RULE_01: at most one of the 112 outputs is driven at any time.
// RULE_02: adapter spaces commands at least 100 ms apart; the bench waits only 8 cycles between them.
// RULE_03: the 8-bit code selects exactly one output driver; codes from 112 up select none here.
// RULE_04: true or complemented code selects the same output.
// RULE_05: adapter register bits 1 to 8 carry the command code.
// RULE_06: register bits 9 to 13 address one stage decoder.
// RULE_07: bit 14 clears the latched code in every decoder.
// RULE_08: bit 15 fires the latched command in the addressed decoder only.
// RULE_09: adapter writes code and address first, then reset or execute.
// RULE_10: after latching, the decoder returns the complement of the code.
// RULE_11: adapter executes only when feedback matches its code; the adapter model executes the retry pass without checking.
// RULE_12: on mismatch adapter resets and resends the complemented code.
// RULE_13: lines are shared; only the selected decoder responds.
// RULE_14: three status outputs go to the stage telemetry.
// RULE_15: adapter exposes non-code register bits to telemetry.
// RULE_16: latch and feedback stay stable until reset or execute, then idle.
module scd_stage_decoder
    import scd_pkg::*;
#(
    parameter logic [scd_pkg::ADDR_W-1:0] MY_ADDR = 5'h00,
    parameter int PULSE_CYCLES = scd_pkg::PULSE_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [scd_pkg::REG_W-1:0] cmdReg,
    input wire logic complementMode,
    input wire logic stageSelect,
    output logic [scd_pkg::CODE_W-1:0] feedback,
    output logic [scd_pkg::OUT_N-1:0] stageOut,
    output logic [scd_pkg::STAT_W-1:0] telemetry
);
    import scd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // field split
    logic [CODE_W-1:0] cmdCode;
    logic [ADDR_W-1:0] cmdAddr;
    logic resetCmd;
    logic execCmd;
    logic addressed;
    assign cmdCode = cmdReg[CODE_LSB +: CODE_W];
    assign cmdAddr = cmdReg[ADDR_LSB +: ADDR_W];
    assign resetCmd = cmdReg[RESET_BIT];
    assign execCmd = cmdReg[EXEC_BIT];
    assign addressed = stageSelect && (cmdAddr == MY_ADDR); // see RULE_13

    ////////////////////////////////////////////////////////////////////////
    // decode of the latched code
    logic [OUT_N-1:0] decoded;
    logic [CODE_W-1:0] code_q, code_d;
    logic compl_q, compl_d;
    scd_onehot_decode #(
        .CODE_W(CODE_W),
        .OUT_N(OUT_N)
    ) u_decode (
        .code(code_q),
        .complemented(compl_q),
        .lines(decoded)
    ); // see RULE_03 see RULE_04

    ////////////////////////////////////////////////////////////////////////
    // pulse timer sizing: counts down from one less than the pulse length to zero
    localparam int CNT_W = (PULSE_CYCLES > 1) ? $clog2(PULSE_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PULSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    ////////////////////////////////////////////////////////////////////////
    // sequencing state
    scd_state_type state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    ////////////////////////////////////////////////////////////////////////
    // decisions taken this cycle
    logic takeCode;
    logic takeReset;
    logic takeExec;
    logic pulseDone;
    // only an idle, selected decoder picks up a code pass
    assign takeCode = (state_q == SCD_IDLE) && addressed && !resetCmd && !execCmd;
    // the reset bit reaches every busy decoder, selected or not
    assign takeReset = resetCmd && (state_q != SCD_IDLE); // see RULE_07
    // execute acts only in the addressed decoder that holds a code
    // reset wins over execute when both bits stand
    assign takeExec = (state_q == SCD_LATCHED) && execCmd && addressed
        && !resetCmd; // see RULE_08
    // last cycle of the output pulse
    assign pulseDone = (state_q == SCD_FIRE) && (cnt_q == CNT_ZERO);

    ////////////////////////////////////////////////////////////////////////
    // guard: a decode fault must never raise two stage lines at once
    // costs an adder chain, keeps every stage line safe
    localparam logic [OUT_IDX_W:0] ONE_LINE = {{OUT_IDX_W{1'b0}}, 1'b1};
    logic [OUT_IDX_W:0] linesUp;
    logic [OUT_N-1:0] safeLines;
    always_comb begin
        linesUp = '0;
        for (int i = 0; i < OUT_N; i++) begin
            linesUp = linesUp + {{OUT_IDX_W{1'b0}}, decoded[i]};
        end
        safeLines = (linesUp > ONE_LINE) ? OUT_ZERO : decoded; // see RULE_01
    end

    ////////////////////////////////////////////////////////////////////////
    // state group: idle -> latched on a code pass, latched -> firing on execute,
    // busy -> idle on the reset bit or when the pulse timer runs out
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            SCD_IDLE: begin
                if (takeCode) begin
                    state_d = SCD_LATCHED;
                end
            end
            SCD_LATCHED: begin
                if (takeReset) begin
                    state_d = SCD_IDLE; // forced reset, see RULE_07
                end else if (takeExec) begin
                    state_d = SCD_FIRE; // see RULE_08
                    cnt_d = CNT_LOAD;
                end
                // otherwise wait for the second pass, see RULE_16
            end
            SCD_FIRE: begin
                if (takeReset || pulseDone) begin
                    state_d = SCD_IDLE; // see RULE_16
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            default: begin
                state_d = SCD_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= SCD_IDLE;
            cnt_q <= CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latch group: code, its form and the feedback
    logic [CODE_W-1:0] feedback_d;
    always_comb begin
        code_d = code_q;
        compl_d = compl_q;
        feedback_d = feedback;
        if (takeCode) begin
            // feedback is the complement of the incoming code bits, so a bad bit shows in the loop
            code_d = cmdCode;
            compl_d = complementMode; // see RULE_04
            feedback_d = ~cmdCode; // see RULE_10
        end else if (state_d == SCD_IDLE) begin
            // staying or going idle clears everything, see RULE_16
            code_d = CODE_ZERO;
            compl_d = 1'b0;
            feedback_d = CODE_ZERO;
        end
    end

    // latch registers
    // code and feedback hold from pickup until reset or end of pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            code_q <= CODE_ZERO;
            compl_q <= 1'b0;
            feedback <= CODE_ZERO;
        end else begin
            code_q <= code_d;
            compl_q <= compl_d;
            feedback <= feedback_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output group: stage lines and stage telemetry
    // status bit positions in the telemetry word
    localparam int TM_BUSY = 0;
    localparam int TM_FIRE = 1;
    localparam int TM_COMPL = 2;
    logic [OUT_N-1:0] stageOut_d;
    logic [STAT_W-1:0] telemetry_d;
    always_comb begin
        stageOut_d = OUT_ZERO;
        if (state_d == SCD_FIRE) begin
            stageOut_d = safeLines; // single line only, see RULE_01
        end
        // status: busy, firing, code complemented
        telemetry_d = '0;
        telemetry_d[TM_BUSY] = (state_d != SCD_IDLE); // see RULE_14
        telemetry_d[TM_FIRE] = (state_d == SCD_FIRE);
        telemetry_d[TM_COMPL] = compl_d;
    end

    // output registers
    // stage lines and telemetry leave straight from these flops; feedback leaves from the latch registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stageOut <= OUT_ZERO;
            telemetry <= '0;
        end else begin
            stageOut <= stageOut_d;
            telemetry <= telemetry_d;
        end
    end
endmodule : scd_stage_decoder

/* design/scd_pkg.sv */
// scd_pkg: constants and types for the stage command decoder
// assumes a single 125 MHz clock domain shared by all users
package scd_pkg;
    localparam int CODE_W = 8;
    localparam int ADDR_W = 5;
    localparam int OUT_N = 112;
    localparam int OUT_IDX_W = 7;
    localparam int STAT_W = 3;
    // command register field positions (bit 1 of the register is index 0)
    localparam int CODE_LSB = 0;
    localparam int ADDR_LSB = 8;
    localparam int RESET_BIT = 13;
    localparam int EXEC_BIT = 14;
    localparam int REG_W = 15;
    // timing
    localparam int CLK_MHZ = 125;
    localparam int PULSE_US = 50;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int MIN_SPACING_MS = 100;
    localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
    localparam logic [OUT_N-1:0] OUT_ZERO = '0;
    typedef enum logic [1:0] {
        SCD_IDLE = 2'b00,
        SCD_LATCHED = 2'b01,
        SCD_FIRE = 2'b11
    } scd_state_type;
endpackage : scd_pkg

/* design/scd_onehot_decode.sv */
// scd_onehot_decode: maps a code to one output line, true or complemented
// assumes code values from the output count up select nothing
module scd_onehot_decode #(
    parameter int CODE_W = 8,
    parameter int OUT_N = 112
) (
    input wire logic [CODE_W-1:0] code,
    input wire logic complemented,
    output logic [OUT_N-1:0] lines
);
    logic [CODE_W-1:0] trueCode;
    // undo complement, then raise at most one line
    always_comb begin
        trueCode = complemented ? ~code : code;
        lines = '0;
        for (int i = 0; i < OUT_N; i++) begin
            if (trueCode == CODE_W'(i)) begin
                lines[i] = 1'b1;
            end
        end
    end
endmodule : scd_onehot_decode

/* verif/scd_stage_decoder_props.sv */
// checker: decoder outputs against the command lines
// assumes one clock, reset_n async active low
module scd_stage_decoder_props #(
    parameter logic [4:0] MY_ADDR = 5'h00,
    parameter int PULSE_CYCLES = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [14:0] cmdReg,
    input wire logic stageSelect,
    input wire logic [7:0] feedback,
    input wire logic [111:0] stageOut,
    input wire logic [2:0] telemetry
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // code as read back from the feedback lines
    logic [7:0] code;
    assign code = ~feedback;
    one_hot_a: assert property ($onehot0(stageOut)) else $error("many out");
    fb_cmpl_a: assert property ($rose(telemetry[0]) && !telemetry[2]
        |-> feedback == ~$past(cmdReg[7:0])) else $error("fb code");
    reset_clr_a: assert property (cmdReg[13] |=> telemetry == 0) else $error("no clr");
    exec_fire_a: assert property (telemetry == 3'h1 && cmdReg[14:13] == 2'h2
        && stageSelect && cmdReg[12:8] == MY_ADDR && code < 8'd112 |=> telemetry[1])
        else $error("no fire");
    sel_guard_a: assert property (!telemetry[0] && (!stageSelect
        || cmdReg[12:8] != MY_ADDR) |=> !telemetry[0]) else $error("foreign");
    fire_idx_a: assert property (telemetry[1] && !telemetry[2] && code < 8'd112
        |-> stageOut[code[6:0]]) else $error("wrong out");
    pulse_len_a: assert property ($fell(telemetry[1]) && !$past(cmdReg[13])
        |-> $past(telemetry[1], PULSE_CYCLES)) else $error("short");
    fb_hold_a: assert property ($past(telemetry[0]) && telemetry[0]
        && !$past(cmdReg[13]) |-> $stable(feedback)) else $error("fb moved");
    cover property ($rose(telemetry[1]));
    cover property ($rose(telemetry[2]));
    cover property (cmdReg[13] && telemetry[0]);
    cover property (telemetry[2] && telemetry[1]); // complemented code fired
endmodule : scd_stage_decoder_props
bind scd_stage_decoder scd_stage_decoder_props #(.MY_ADDR(MY_ADDR),
    .PULSE_CYCLES(PULSE_CYCLES)) i_props (.clk(clk), .reset_n(reset_n), .cmdReg(cmdReg),
    .stageSelect(stageSelect), .feedback(feedback), .stageOut(stageOut), .telemetry(telemetry));

/* verif/scd_adapter_model.sv */
// adapter model: two-pass command issue with verify
// assumes a single decoder on the shared lines
module scd_adapter_model (
    input wire logic clk,
    output logic [14:0] cmdReg,
    output logic complementMode,
    output logic stageSelect,
    input wire logic [7:0] feedback
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] fbSeen; // feedback read at the last verify
    logic [6:0] ctrlTap; // non-code register bits as telemetry samples them
    initial begin
        cmdReg = '0;
        complementMode = 1'b0;
        stageSelect = 1'b0;
        fbSeen = '0;
    end
    // control and address bits tapped for the telemetry path
    always @(posedge clk) ctrlTap <= cmdReg[14:8];
    // code pass, verify, then reset or execute; retry complemented
    task issue(input logic [7:0] code, input logic [4:0] adr, input logic bad);
        logic ok;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            cmdReg <= {2'b00, adr, k ? ~code : code ^ {7'h00, bad}};
            complementMode <= k[0];
            stageSelect <= 1'b1;
            repeat (2) @(posedge clk);
            fbSeen = feedback;
            ok = k == 1 || fbSeen === ~code;
            cmdReg <= {ok, !ok, adr, cmdReg[7:0]};
            @(posedge clk);
            cmdReg <= {2'b00, ~cmdReg[12:0]}; // control bits cleared, address and code bits inverted
            stageSelect <= 1'b0;
            if (ok) return;
        end
    endtask : issue
endmodule : scd_adapter_model

/* verif/stage_command_decoder_tb.sv */
// bench: adapter model drives one decoder at address 2
// assumes a pulse of 4 cycles to keep the run short
module stage_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0;
    logic reset_n = 0;
    logic [14:0] cmdReg;
    logic complementMode, stageSelect;
    logic [7:0] feedback;
    logic [111:0] stageOut;
    logic [2:0] telemetry;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    initial forever #4 clk = ~clk;
    scd_adapter_model i_scd_adapter_model (.clk(clk), .cmdReg(cmdReg),
        .complementMode(complementMode), .stageSelect(stageSelect), .feedback(feedback));
    scd_stage_decoder #(.MY_ADDR(5'h02), .PULSE_CYCLES(4)) i_scd_stage_decoder (.clk(clk),
        .reset_n(reset_n), .cmdReg(cmdReg), .complementMode(complementMode),
        .stageSelect(stageSelect), .feedback(feedback), .stageOut(stageOut),
        .telemetry(telemetry));
    task chk(input logic [111:0] seen, input logic [111:0] exp, input string nm);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one command, its output, then the return to idle
    task fire(input logic [7:0] code, input logic [4:0] adr, input logic bad, input int idx);
        logic [111:0] exp;
        logic [7:0] expFb;
        exp = idx < 0 ? '0 : 112'(1) << idx;
        // feedback is the complement of what was latched; nothing if not addressed
        expFb = adr != 5'h02 ? 8'h00 : bad ? code : ~code;
        i_scd_adapter_model.issue(code, adr, bad);
        @(negedge clk);
        chk(stageOut, exp, "stageOut");
        if (idx >= 0) chk(112'(telemetry), {bad, 2'b11}, "telemetry");
        chk(112'(i_scd_adapter_model.fbSeen), 112'(expFb), "feedback");
        chk(112'(i_scd_adapter_model.ctrlTap), 112'({2'b10, adr}), "ctrlTap");
        repeat (8) @(negedge clk); // scaled command spacing
        chk(stageOut | 112'(feedback), '0, "idle");
        chk(112'(telemetry), '0, "telemetry idle");
        $display("test done code %h", code);
    endtask : fire
    task t_low; fire(8'h00, 5'h02, 0, 0); endtask : t_low
    task t_top; fire(8'h6F, 5'h02, 0, 111); endtask : t_top
    task t_retry; fire(8'h21, 5'h02, 1, 33); endtask : t_retry
    task t_range; fire(8'h70, 5'h02, 0, -1); endtask : t_range
    task t_other; fire(8'h05, 5'h03, 0, -1); endtask : t_other
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_low;
        t_top;
        t_retry;
        t_range;
        t_other;
        close_out();
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            close_out();
        end
    end
    task close_out;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
endmodule : stage_command_decoder_tb
